// ==== core/port_pin_pkg.sv ====
// Constants, layouts and carrier types for the port pin control block
package port_pin_pkg;
  localparam int ADDR_W = 9;
  localparam int PIN_W  = 57;

  // Register offsets
  localparam logic [8:0] OFS_PORTA_DIR  = 9'h002;
  localparam logic [8:0] OFS_PORTB_DIR  = 9'h003;
  localparam logic [8:0] OFS_PORTE_DIR  = 9'h009;
  localparam logic [8:0] OFS_PULL_CTRL  = 9'h00c;
  localparam logic [8:0] OFS_LOW_DRIVE  = 9'h00d;
  localparam logic [8:0] OFS_H_DATA     = 9'h024;
  localparam logic [8:0] OFS_H_DIR      = 9'h025;
  localparam logic [8:0] OFS_PWM_ENABLE = 9'h040;
  localparam logic [8:0] OFS_PWM_CTRL   = 9'h054;
  localparam logic [8:0] OFS_P_DATA     = 9'h056;
  localparam logic [8:0] OFS_P_DIR      = 9'h057;
  localparam logic [8:0] OFS_CONV0_CTRL = 9'h062;
  localparam logic [8:0] OFS_AN0_DATA   = 9'h06f;
  localparam logic [8:0] OFS_TIMER_SYS  = 9'h086;
  localparam logic [8:0] OFS_TIMER_MASK = 9'h08d;
  localparam logic [8:0] OFS_PA_CTRL    = 9'h0a0;
  localparam logic [8:0] OFS_T_DATA     = 9'h0ae;
  localparam logic [8:0] OFS_T_DIR      = 9'h0af;
  localparam logic [8:0] OFS_SER_CTRL   = 9'h0c2;
  localparam logic [8:0] OFS_SPI_CTRL   = 9'h0d0;
  localparam logic [8:0] OFS_S_DATA     = 9'h0d6;
  localparam logic [8:0] OFS_S_DIR      = 9'h0d7;
  localparam logic [8:0] OFS_S_PULLDRV  = 9'h0d9;
  localparam logic [8:0] OFS_CONV1_CTRL = 9'h0e2;
  localparam logic [8:0] OFS_AN1_DATA   = 9'h0ef;
  localparam logic [8:0] OFS_CAN_DATA   = 9'h13e;

  // Field positions
  localparam int H_PULL_BIT     = 7;
  localparam int H_LOWDRV_BIT   = 6;
  localparam int P_PULL_BIT     = 3;
  localparam int P_LOWDRV_BIT   = 4;
  localparam int T_PULL_BIT     = 5;
  localparam int T_LOWDRV_BIT   = 4;
  localparam int CONV_PWRUP_BIT = 7;
  localparam int TIMER_EN_BIT   = 7;
  localparam int PA_EN_BIT      = 6;
  localparam int SPI_WO_BIT     = 0;
  localparam int S_LOWDRV_LSB   = 4;

  // Values after reset and bit masks
  localparam logic       H_PULL_RST  = 1'b1;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [7:0] PORTE_MASK  = 8'hfc;
  localparam logic [7:0] PWM_CH_MASK = 8'h0f;
  localparam logic [7:0] PA_PIN_MASK = 8'h80;

  // Port indices of the general-purpose pad array
  localparam int PORT_H = 0;
  localparam int PORT_P = 1;
  localparam int PORT_S = 2;
  localparam int PORT_T = 3;
  localparam int NPORTS = 4;

  // Layout of the synchronised pin vector
  localparam int PIN_CAN_LSB = 32;
  localparam int PIN_AN0_LSB = 40;
  localparam int PIN_AN1_LSB = 48;
  localparam int PIN_LT_BIT  = 56;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_EXPANDED, MODE_PERIPH} bus_mode_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] low_drive;
  } pad_t;

  typedef struct packed {
    logic [7:0] claim;
    logic [7:0] val;
    logic [7:0] oe;
  } periph_t;
endpackage

// ==== core/port_pin_control.sv ====
// Pin control for ports H, CAN, analog 0/1, P, S and T with a plain register port
`timescale 1ns/100ps
module port_pin_control
  import port_pin_pkg::*;
(
  input  wire logic                    ref_clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    ce_in,
  input  wire bus_mode_t               mode_in,
  input  wire logic [ADDR_W-1:0]       addr_in,
  input  wire logic [7:0]              wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic [7:0]                   rdata_out,
  input  wire logic [NPORTS-1:0][7:0]  gpio_pin_in,
  output pad_t [NPORTS-1:0]            gpio_pad_out,
  input  wire logic                    h_load_type_select_in,
  input  wire logic [7:0]              can_pin_in,
  input  wire logic                    can_tx_in,
  input  wire pad_t                    can_hi_in,
  output logic                         can_transmit_pin_out,
  output pad_t                         can_hi_pad_out,
  output logic                         can_receive_out,
  input  wire logic [7:0]              analog0_pin_in,
  input  wire logic [7:0]              analog1_pin_in,
  output logic [1:0]                   converter_power_up_out,
  input  wire periph_t                 pwm_in,
  input  wire periph_t                 serial_in,
  input  wire logic [2:0]              serial_group_en_in,
  input  wire periph_t                 timer_in,
  output logic [3:0]                   pwm_channel_enable_out,
  output logic                         timer_enable_out,
  output logic                         pulse_accum_enable_out,
  output logic [7:0]                   porta_direction_out,
  output logic [7:0]                   portb_direction_out,
  output logic [7:0]                   porte_direction_out
);

  // Expand a three-group enable onto port S pins 1:0, 3:2 and 7:4
  function automatic logic [7:0] grp_mask(input logic [2:0] g);
    grp_mask = {{4{g[2]}}, {2{g[1]}}, {2{g[0]}}};
  endfunction

  // Pin synchroniser: s1 feeds only s2; the filtered copy moves when s2 and s3 agree
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [PIN_W-1:0] pins_raw;

  assign pins_raw = {h_load_type_select_in, analog1_pin_in, analog0_pin_in, can_pin_in, gpio_pin_in};

  always_comb begin
    filt_d = filt_q;
    for (int k = 0; k < PIN_W; k++) begin
      if (s2_q[k] == s3_q[k]) begin
        filt_d[k] = s3_q[k];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else if (ce_in) begin
      // Clock enable low freezes the synchroniser along with every register
      s1_q   <= pins_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  logic [NPORTS-1:0][7:0] pin_lvl;
  logic [7:0]             can_lvl, an0_lvl, an1_lvl;
  logic                   load_up;

  assign pin_lvl = filt_q[31:0];
  assign can_lvl = filt_q[PIN_CAN_LSB +: 8];
  // Analog pins have no pad: read only, never driven, pulled or weakened
  assign an0_lvl = filt_q[PIN_AN0_LSB +: 8];
  assign an1_lvl = filt_q[PIN_AN1_LSB +: 8];
  assign load_up = filt_q[PIN_LT_BIT];

  // Register file
  logic [NPORTS-1:0][7:0] data_q, data_d;
  logic [NPORTS-1:0][7:0] dir_q, dir_d;
  logic [7:0]             pa_dir_q, pa_dir_d;
  logic [7:0]             pb_dir_q, pb_dir_d;
  logic [7:0]             pe_dir_q, pe_dir_d;
  logic                   h_pull_q, h_pull_d;
  logic                   h_lowdrv_q, h_lowdrv_d;
  logic                   lowdrv_used_q, lowdrv_used_d;
  logic [7:0]             pwm_en_q, pwm_en_d;
  logic [7:0]             pwm_ctrl_q, pwm_ctrl_d;
  logic [7:0]             conv0_q, conv0_d;
  logic [7:0]             conv1_q, conv1_d;
  logic [7:0]             tsys_q, tsys_d;
  logic [7:0]             tmask_q, tmask_d;
  logic [7:0]             pulse_accum_control_q, pulse_accum_control_d;
  logic [7:0]             ser_ctrl_q, ser_ctrl_d;
  logic [7:0]             spi_ctrl_q, spi_ctrl_d;
  logic [7:0]             s_pd_q, s_pd_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   single_chip, periph_mode;

  // Mode is decoded live, so a mode change governs the very next access
  assign single_chip = (mode_in == MODE_SINGLE);
  assign periph_mode = (mode_in == MODE_PERIPH);

  // Read value of a port data register
  logic [NPORTS-1:0][7:0] port_rd;

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      port_rd[p] = (dir_q[p] & data_q[p]) | (~dir_q[p] & pin_lvl[p]);
    end
  end

  always_comb begin
    data_d        = data_q;
    dir_d         = dir_q;
    pa_dir_d      = pa_dir_q;
    pb_dir_d      = pb_dir_q;
    pe_dir_d      = pe_dir_q;
    h_pull_d      = h_pull_q;
    h_lowdrv_d    = h_lowdrv_q;
    lowdrv_used_d = lowdrv_used_q;
    pwm_en_d      = pwm_en_q;
    pwm_ctrl_d    = pwm_ctrl_q;
    conv0_d       = conv0_q;
    conv1_d       = conv1_q;
    tsys_d        = tsys_q;
    tmask_d       = tmask_q;
    pulse_accum_control_d       = pulse_accum_control_q;
    ser_ctrl_d    = ser_ctrl_q;
    spi_ctrl_d    = spi_ctrl_q;
    s_pd_d        = s_pd_q;
    rdata_d       = REG_RST;
    if (wr_in) begin
      case (addr_in)
        OFS_PORTA_DIR:  if (single_chip) pa_dir_d = wdata_in;
        OFS_PORTB_DIR:  if (single_chip) pb_dir_d = wdata_in;
        OFS_PORTE_DIR:  if (!periph_mode) pe_dir_d = wdata_in & PORTE_MASK;
        OFS_PULL_CTRL:  h_pull_d = wdata_in[H_PULL_BIT];
        OFS_LOW_DRIVE: begin
          // Only the first write outside peripheral mode after reset lands; later ones are dropped
          if (!periph_mode && !lowdrv_used_q) begin
            h_lowdrv_d    = wdata_in[H_LOWDRV_BIT];
            lowdrv_used_d = 1'b1;
          end
        end
        OFS_H_DATA:     data_d[PORT_H] = wdata_in;
        OFS_H_DIR:      dir_d[PORT_H] = wdata_in;
        OFS_PWM_ENABLE: pwm_en_d = wdata_in & PWM_CH_MASK;
        OFS_PWM_CTRL:   pwm_ctrl_d = wdata_in;
        OFS_P_DATA:     data_d[PORT_P] = wdata_in;
        OFS_P_DIR:      dir_d[PORT_P] = wdata_in;
        OFS_CONV0_CTRL: conv0_d = wdata_in;
        OFS_CONV1_CTRL: conv1_d = wdata_in;
        OFS_TIMER_SYS:  tsys_d = wdata_in;
        OFS_TIMER_MASK: tmask_d = wdata_in;
        OFS_PA_CTRL:    pulse_accum_control_d = wdata_in;
        OFS_T_DATA:     data_d[PORT_T] = wdata_in;
        OFS_T_DIR:      dir_d[PORT_T] = wdata_in;
        OFS_SER_CTRL:   ser_ctrl_d = wdata_in;
        OFS_SPI_CTRL:   spi_ctrl_d = wdata_in;
        OFS_S_DATA:     data_d[PORT_S] = wdata_in;
        OFS_S_DIR:      dir_d[PORT_S] = wdata_in;
        OFS_S_PULLDRV:  s_pd_d = wdata_in;
        default:        ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        OFS_PORTA_DIR:  rdata_d = single_chip ? pa_dir_q : REG_RST;
        OFS_PORTB_DIR:  rdata_d = single_chip ? pb_dir_q : REG_RST;
        OFS_PORTE_DIR:  rdata_d = periph_mode ? REG_RST : pe_dir_q;
        OFS_PULL_CTRL:  rdata_d = 8'(h_pull_q) << H_PULL_BIT;
        OFS_LOW_DRIVE:  rdata_d = periph_mode ? REG_RST : 8'(h_lowdrv_q) << H_LOWDRV_BIT;
        OFS_H_DATA:     rdata_d = port_rd[PORT_H];
        OFS_H_DIR:      rdata_d = dir_q[PORT_H];
        OFS_PWM_ENABLE: rdata_d = pwm_en_q;
        OFS_PWM_CTRL:   rdata_d = pwm_ctrl_q;
        OFS_P_DATA:     rdata_d = port_rd[PORT_P];
        OFS_P_DIR:      rdata_d = dir_q[PORT_P];
        OFS_CONV0_CTRL: rdata_d = conv0_q;
        OFS_CONV1_CTRL: rdata_d = conv1_q;
        // Powered-up analog ports read zero: the pins belong to the converter
        OFS_AN0_DATA:   rdata_d = conv0_q[CONV_PWRUP_BIT] ? REG_RST : an0_lvl;
        OFS_AN1_DATA:   rdata_d = conv1_q[CONV_PWRUP_BIT] ? REG_RST : an1_lvl;
        OFS_TIMER_SYS:  rdata_d = tsys_q;
        OFS_TIMER_MASK: rdata_d = tmask_q;
        OFS_PA_CTRL:    rdata_d = pulse_accum_control_q;
        OFS_T_DATA:     rdata_d = port_rd[PORT_T];
        OFS_T_DIR:      rdata_d = dir_q[PORT_T];
        OFS_SER_CTRL:   rdata_d = ser_ctrl_q;
        OFS_SPI_CTRL:   rdata_d = spi_ctrl_q;
        OFS_S_DATA:     rdata_d = port_rd[PORT_S];
        OFS_S_DIR:      rdata_d = dir_q[PORT_S];
        OFS_S_PULLDRV:  rdata_d = s_pd_q;
        OFS_CAN_DATA:   rdata_d = can_lvl;
        default:        rdata_d = REG_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_q        <= '0;
      dir_q         <= '0;
      pa_dir_q      <= REG_RST;
      pb_dir_q      <= REG_RST;
      pe_dir_q      <= REG_RST;
      h_pull_q      <= H_PULL_RST;
      h_lowdrv_q    <= 1'b0;
      lowdrv_used_q <= 1'b0;
      pwm_en_q      <= REG_RST;
      pwm_ctrl_q    <= REG_RST;
      conv0_q       <= REG_RST;
      conv1_q       <= REG_RST;
      tsys_q        <= REG_RST;
      tmask_q       <= REG_RST;
      pulse_accum_control_q       <= REG_RST;
      ser_ctrl_q    <= REG_RST;
      spi_ctrl_q    <= REG_RST;
      s_pd_q        <= REG_RST;
      rdata_q       <= REG_RST;
    end else if (ce_in) begin
      data_q        <= data_d;
      dir_q         <= dir_d;
      pa_dir_q      <= pa_dir_d;
      pb_dir_q      <= pb_dir_d;
      pe_dir_q      <= pe_dir_d;
      h_pull_q      <= h_pull_d;
      h_lowdrv_q    <= h_lowdrv_d;
      lowdrv_used_q <= lowdrv_used_d;
      pwm_en_q      <= pwm_en_d;
      pwm_ctrl_q    <= pwm_ctrl_d;
      conv0_q       <= conv0_d;
      conv1_q       <= conv1_d;
      tsys_q        <= tsys_d;
      tmask_q       <= tmask_d;
      pulse_accum_control_q       <= pulse_accum_control_d;
      ser_ctrl_q    <= ser_ctrl_d;
      spi_ctrl_q    <= spi_ctrl_d;
      s_pd_q        <= s_pd_d;
      rdata_q       <= rdata_d;
    end
  end

  // Per-port controls feeding the common pad logic
  logic [NPORTS-1:0][7:0] claim, pval, poe, wo, pu_en, pd_en, ld_en, pull_gpio_only;
  logic [7:0]             tim_claim;

  // Timer claims reach port T only while the timer is enabled
  assign tim_claim = tsys_q[TIMER_EN_BIT] ? timer_in.claim : REG_RST;

  always_comb begin
    claim          = '0;
    pval           = '0;
    poe            = '0;
    wo             = '0;
    pu_en          = '0;
    pd_en          = '0;
    ld_en          = '0;
    pull_gpio_only = '0;
    // Port H: pull type follows the load-select pin
    pu_en[PORT_H] = {8{h_pull_q & load_up}};
    pd_en[PORT_H] = {8{h_pull_q & ~load_up}};
    ld_en[PORT_H] = {8{h_lowdrv_q}};
    // Port P
    claim[PORT_P] = pwm_en_q & PWM_CH_MASK;
    pval[PORT_P]  = pwm_in.val;
    poe[PORT_P]   = PWM_CH_MASK;
    pu_en[PORT_P] = {8{pwm_ctrl_q[P_PULL_BIT]}};
    ld_en[PORT_P] = {8{pwm_ctrl_q[P_LOWDRV_BIT]}};
    // Port S
    claim[PORT_S] = serial_in.claim & grp_mask(serial_group_en_in);
    pval[PORT_S]  = serial_in.val;
    poe[PORT_S]   = serial_in.oe;
    wo[PORT_S]    = grp_mask({spi_ctrl_q[SPI_WO_BIT], ser_ctrl_q[1:0]});
    pu_en[PORT_S] = grp_mask(s_pd_q[2:0]);
    ld_en[PORT_S] = grp_mask(s_pd_q[S_LOWDRV_LSB +: 3]);
    pull_gpio_only[PORT_S] = 8'hff;
    // Port T: pulse accumulator holds pin 7 as an input unless the enabled timer claims it with output enable
    claim[PORT_T] = tim_claim | (pulse_accum_control_q[PA_EN_BIT] ? PA_PIN_MASK : REG_RST);
    pval[PORT_T]  = timer_in.val;
    poe[PORT_T]   = timer_in.oe & tim_claim;
    pu_en[PORT_T] = {8{tmask_q[T_PULL_BIT]}};
    ld_en[PORT_T] = {8{tmask_q[T_LOWDRV_BIT]}};
  end

  // Pad outputs, registered so every pin control leaves a flip-flop
  pad_t [NPORTS-1:0] pad_q, pad_d;

  for (genvar p = 0; p < NPORTS; p++) begin : g_pad
    logic [7:0] drv_val, drv_en, in_mask;

    assign drv_val = (claim[p] & pval[p]) | (~claim[p] & data_q[p]);
    assign drv_en  = (claim[p] & poe[p]) | (~claim[p] & dir_q[p]);
    assign in_mask = ~drv_en & ~(pull_gpio_only[p] & claim[p]);

    always_comb begin
      pad_d[p].out       = drv_val;
      // Open drain: a high level releases the pin instead of driving it
      pad_d[p].oe        = drv_en & ~(wo[p] & drv_val);
      pad_d[p].pull_up   = pu_en[p] & in_mask;
      pad_d[p].pull_down = pd_en[p] & in_mask;
      pad_d[p].low_drive = ld_en[p] & drv_en;
    end
  end

  // CAN pins: transmit passes the bus level untouched, high pins belong to the CAN module
  logic can_tx_q, can_tx_d;
  pad_t can_hi_q, can_hi_d;

  always_comb begin
    can_tx_d = can_tx_in;
    can_hi_d = can_hi_in;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_q    <= '0;
      can_tx_q <= 1'b1;
      can_hi_q <= '0;
    end else if (ce_in) begin
      pad_q    <= pad_d;
      can_tx_q <= can_tx_d;
      can_hi_q <= can_hi_d;
    end
  end

  assign rdata_out              = rdata_q;
  assign gpio_pad_out           = pad_q;
  assign can_transmit_pin_out   = can_tx_q;
  assign can_hi_pad_out         = can_hi_q;
  assign can_receive_out        = filt_q[PIN_CAN_LSB];
  assign converter_power_up_out = {conv1_q[CONV_PWRUP_BIT], conv0_q[CONV_PWRUP_BIT]};
  assign pwm_channel_enable_out = pwm_en_q[3:0];
  assign timer_enable_out       = tsys_q[TIMER_EN_BIT];
  assign pulse_accum_enable_out = pulse_accum_control_q[PA_EN_BIT];
  assign porta_direction_out    = pa_dir_q;
  assign portb_direction_out    = pb_dir_q;
  assign porte_direction_out    = pe_dir_q;

endmodule

// ==== tb/pin_monitor.sv ====
// Concurrent checks on the port pin control ports
`timescale 1ns/100ps
module pin_monitor
  import port_pin_pkg::*;
(
  input wire logic              ref_clk_in,
  input wire logic              nrst_in,
  input wire logic              ce_in,
  input wire bus_mode_t         mode_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0]        wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [7:0]        rdata_out,
  input wire pad_t [NPORTS-1:0] gpio_pad_out,
  input wire logic              can_tx_in,
  input wire logic              can_transmit_pin_out,
  input wire logic [1:0]        converter_power_up_out,
  input wire periph_t           pwm_in,
  input wire logic [3:0]        pwm_channel_enable_out,
  input wire logic              timer_enable_out,
  input wire logic              pulse_accum_enable_out,
  input wire logic [7:0]        porta_direction_out
);
  pad_t       ph, pp, ps, pt;
  logic [3:0] pwm_live;
  assign ph = gpio_pad_out[PORT_H];
  assign pp = gpio_pad_out[PORT_P];
  assign ps = gpio_pad_out[PORT_S];
  assign pt = gpio_pad_out[PORT_T];
  assign pwm_live = pwm_channel_enable_out & pwm_in.claim[3:0];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  chk_can_tx_level: assert property (ce_in |=> can_transmit_pin_out == $past(can_tx_in))
    else $error("tx pin lost tx level");
  chk_h_dir_drive: assert property (ce_in && wr_in && addr_in == OFS_H_DIR ##1 ce_in
    |=> ph.oe == $past(wdata_in, 2)) else $error("port h drive differs from direction");
  chk_p_dir_drive: assert property (ce_in && wr_in && addr_in == OFS_P_DIR ##1 ce_in
    |=> pp.oe[7:4] == $past(wdata_in[7:4], 2)) else $error("port p drive differs from direction");
  chk_t_dir_drive: assert property (ce_in && wr_in && addr_in == OFS_T_DIR && !timer_enable_out
    && !pulse_accum_enable_out ##1 ce_in |=> pt.oe == $past(wdata_in, 2)) else $error("port t drive wrong");
  chk_h_pull_inputs: assert property ((((ph.pull_up | ph.pull_down) & ph.oe) | (ph.pull_up & ph.pull_down))
    == 8'h00) else $error("port h load on driven pin");
  chk_pst_pull_inputs: assert property (((pp.pull_up & pp.oe) | (ps.pull_up & ps.oe) | (pt.pull_up & pt.oe))
    == 8'h00) else $error("pull-up on driven pin");
  chk_pwm_takes_pin: assert property (ce_in |=> ((pp.out[3:0] ^ $past(pwm_in.val[3:0])) & $past(pwm_live))
    == 4'h0) else $error("pwm level not on pin");
  chk_analog_powered: assert property (ce_in && rd_in && addr_in == OFS_AN0_DATA && converter_power_up_out[0]
    |=> rdata_out == 8'h00) else $error("analog read while powered");
  chk_porta_mode_lock: assert property (ce_in && wr_in && addr_in == OFS_PORTA_DIR && mode_in != MODE_SINGLE
    |=> $stable(porta_direction_out)) else $error("port a direction written outside single chip");
  chk_rdata_idle: assert property (ce_in && !rd_in |=> rdata_out == 8'h00)
    else $error("read data without read");
endmodule

// ==== tb/board_model.sv ====
// Board side: resolves every pin of ports H, P, S and T from pad drive, pulls and outside sources
`timescale 1ns/100ps
module board_model
  import port_pin_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire pad_t [NPORTS-1:0]      pad_in,
  input  wire logic [NPORTS-1:0][7:0] ext_in,
  input  wire logic [NPORTS-1:0][7:0] ext_en_in,
  output logic [NPORTS-1:0][7:0]      pin_out
);
  logic [7:0] float_q;

  // A floating pin flips every cycle, so the synchroniser filter never accepts it and holds the last settled level
  always_ff @(posedge ref_clk_in) begin
    float_q <= (float_q === 8'h55) ? 8'haa : 8'h55;
  end

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_in[p].oe[b]) begin
          pin_out[p][b] = pad_in[p].out[b];
        end else if (ext_en_in[p][b]) begin
          pin_out[p][b] = ext_in[p][b];
        end else if (pad_in[p].pull_up[b]) begin
          pin_out[p][b] = 1'b1;
        end else if (pad_in[p].pull_down[b]) begin
          pin_out[p][b] = 1'b0;
        end else begin
          pin_out[p][b] = float_q[b];
        end
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the port pin control block
`timescale 1ns/100ps
module tb
  import port_pin_pkg::*;
;
  logic                   clk, nrst, ce, wr, rd, lts, ctx, ctxp, crx, timer_enable_bit, pulse_accum_enable;
  bus_mode_t              mode;
  logic [ADDR_W-1:0]      addr;
  logic [7:0]             wdata, rdata, canp, an0, an1, dira, dirb, dire;
  logic [NPORTS-1:0][7:0] pins, ext, exte;
  pad_t [NPORTS-1:0]      pads;
  pad_t                   chi, chp;
  periph_t                pwm, ser, tmr;
  logic [2:0]             sge;
  logic [1:0]             pwr;
  logic [3:0]             pwm_channel_enable;
  int                     bad_count, samples_checked;

  port_pin_control u_port_pin_control (
    .ref_clk_in(clk), .nrst_in(nrst), .ce_in(ce), .mode_in(mode), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .gpio_pin_in(pins), .gpio_pad_out(pads),
    .h_load_type_select_in(lts), .can_pin_in(canp), .can_tx_in(ctx), .can_hi_in(chi),
    .can_transmit_pin_out(ctxp), .can_hi_pad_out(chp), .can_receive_out(crx), .analog0_pin_in(an0),
    .analog1_pin_in(an1), .converter_power_up_out(pwr), .pwm_in(pwm), .serial_in(ser),
    .serial_group_en_in(sge), .timer_in(tmr), .pwm_channel_enable_out(pwm_channel_enable), .timer_enable_out(timer_enable_bit),
    .pulse_accum_enable_out(pulse_accum_enable), .porta_direction_out(dira), .portb_direction_out(dirb),
    .porte_direction_out(dire));
  board_model u_board_model (.ref_clk_in(clk), .pad_in(pads), .ext_in(ext), .ext_en_in(exte), .pin_out(pins));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rreg(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Covers the pin synchroniser and the pad register lag
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    rreg(OFS_H_DIR, 8'h00);
    rreg(OFS_P_DIR, 8'h00);
    rreg(OFS_T_DIR, 8'h00);
    rreg(OFS_PULL_CTRL, 8'h80);
    rreg(OFS_PWM_CTRL, 8'h00);
    rreg(OFS_TIMER_MASK, 8'h00);
    rreg(9'h1ff, 8'h00);
  endtask

  task automatic t_port_h;
    @(posedge clk);
    exte[PORT_H] <= 8'h00;
    wreg(OFS_H_DIR, 8'hf0);
    wreg(OFS_H_DATA, 8'ha5);
    settle;
    chk(pads[PORT_H].oe, 8'hf0);
    chk(pads[PORT_H].pull_down, 8'h0f);
    rreg(OFS_H_DATA, 8'ha0);
    @(posedge clk);
    lts <= 1'b1;
    settle;
    chk(pads[PORT_H].pull_up, 8'h0f);
    settle;
    rreg(OFS_H_DATA, 8'haf);
    @(posedge clk);
    mode <= MODE_PERIPH;
    wreg(OFS_LOW_DRIVE, 8'h40);
    rreg(OFS_LOW_DRIVE, 8'h00);
    @(posedge clk);
    mode <= MODE_SINGLE;
    wreg(OFS_LOW_DRIVE, 8'h40);
    wreg(OFS_LOW_DRIVE, 8'h00);
    rreg(OFS_LOW_DRIVE, 8'h40);
    settle;
    chk(pads[PORT_H].low_drive, 8'hf0);
  endtask

  // A write with the clock enable low must leave every register alone
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wreg(OFS_H_DIR, 8'h0f);
    @(posedge clk);
    ce <= 1'b1;
    rreg(OFS_H_DIR, 8'hf0);
    chk(pads[PORT_H].oe, 8'hf0);
  endtask

  task automatic t_can_analog;
    @(posedge clk);
    ctx <= 1'b0;
    canp <= 8'hfd;
    an0 <= 8'h5a;
    an1 <= 8'hc3;
    chi <= {8'hfc, 8'h0c, 8'h30, 8'h00, 8'hc0};
    settle;
    chk({7'h0, ctxp}, 8'h00);
    chk(chp.out, 8'hfc);
    chk(chp.low_drive, 8'hc0);
    chk({7'h0, crx}, 8'h01);
    wreg(OFS_CAN_DATA, 8'h00);
    rreg(OFS_CAN_DATA, 8'hfd);
    rreg(OFS_AN0_DATA, 8'h5a);
    rreg(OFS_AN1_DATA, 8'hc3);
    wreg(OFS_CONV0_CTRL, 8'h80);
    wreg(OFS_CONV1_CTRL, 8'h80);
    rreg(OFS_AN0_DATA, 8'h00);
    rreg(OFS_AN1_DATA, 8'h00);
    chk({6'h0, pwr, ctxp}, 8'h06);
  endtask

  task automatic t_pwm;
    wreg(OFS_P_DIR, 8'hff);
    wreg(OFS_P_DATA, 8'h00);
    @(posedge clk);
    pwm <= {8'h0f, 8'h0a, 8'h0f};
    wreg(OFS_PWM_ENABLE, 8'h0f);
    settle;
    chk(pads[PORT_P].out, 8'h0a);
    chk({4'h0, pwm_channel_enable}, 8'h0f);
    wreg(OFS_P_DIR, 8'h0f);
    wreg(OFS_PWM_CTRL, 8'h18);
    rreg(OFS_PWM_CTRL, 8'h18);
    settle;
    chk(pads[PORT_P].pull_up, 8'hf0);
    chk(pads[PORT_P].low_drive, 8'h0f);
  endtask

  task automatic t_serial;
    wreg(OFS_S_DIR, 8'hff);
    wreg(OFS_SPI_CTRL, 8'h01);
    wreg(OFS_SER_CTRL, 8'h03);
    wreg(OFS_S_DATA, 8'h3c);
    settle;
    chk(pads[PORT_S].oe, 8'hc3);
    wreg(OFS_S_DATA, 8'h00);
    wreg(OFS_S_DIR, 8'h0f);
    wreg(OFS_S_PULLDRV, 8'h14);
    settle;
    chk(pads[PORT_S].pull_up, 8'hf0);
    chk(pads[PORT_S].low_drive, 8'h03);
    @(posedge clk);
    sge <= 3'b100;
    ser <= {8'hf0, 8'h50, 8'hf0};
    settle;
    chk(pads[PORT_S].out & 8'hf0, 8'h50);
    chk(pads[PORT_S].pull_up, 8'h00);
  endtask

  task automatic t_timer;
    wreg(OFS_T_DIR, 8'hff);
    wreg(OFS_T_DATA, 8'h55);
    settle;
    chk(pads[PORT_T].out, 8'h55);
    wreg(OFS_TIMER_SYS, 8'h80);
    @(posedge clk);
    tmr <= {8'h0f, 8'h0a, 8'h0f};
    wreg(OFS_PA_CTRL, 8'h40);
    wreg(OFS_TIMER_MASK, 8'h30);
    rreg(OFS_TIMER_MASK, 8'h30);
    settle;
    chk(pads[PORT_T].out & 8'h0f, 8'h0a);
    chk(pads[PORT_T].oe, 8'h7f);
    chk(pads[PORT_T].pull_up, 8'h80);
    chk(pads[PORT_T].low_drive, 8'h7f);
    chk({6'h0, timer_enable_bit, pulse_accum_enable}, 8'h03);
  endtask

  task automatic t_mode;
    @(posedge clk);
    mode <= MODE_EXPANDED;
    wreg(OFS_PORTA_DIR, 8'hff);
    wreg(OFS_PORTB_DIR, 8'hff);
    wreg(OFS_PORTE_DIR, 8'hff);
    rreg(OFS_PORTA_DIR, 8'h00);
    chk(dira | dirb, 8'h00);
    chk(dire, 8'hfc);
    @(posedge clk);
    mode <= MODE_SINGLE;
    wreg(OFS_PORTA_DIR, 8'h3c);
    wreg(OFS_PORTB_DIR, 8'hc3);
    rreg(OFS_PORTB_DIR, 8'hc3);
    chk(dira, 8'h3c);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    bad_count = 0;
    samples_checked = 0;
    {ce, nrst, wr, rd, lts, ctx} = 6'b100001;
    mode = MODE_SINGLE;
    addr = '0;
    wdata = '0;
    canp = 8'hff;
    {an0, an1, ext, chi, pwm, ser, tmr, sge} = '0;
    exte = '1;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_port_h;
    t_freeze;
    t_can_analog;
    t_pwm;
    t_serial;
    t_timer;
    t_mode;
    summarize;
  end

  // The sequence needs well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
endmodule

bind port_pin_control pin_monitor u_pin_monitor (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .mode_in(mode_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gpio_pad_out(gpio_pad_out),
  .can_tx_in(can_tx_in), .can_transmit_pin_out(can_transmit_pin_out),
  .converter_power_up_out(converter_power_up_out), .pwm_in(pwm_in),
  .pwm_channel_enable_out(pwm_channel_enable_out), .timer_enable_out(timer_enable_out),
  .pulse_accum_enable_out(pulse_accum_enable_out), .porta_direction_out(porta_direction_out));
